// ===== bench/scwg_host_model.sv
// Host model issuing command frames
`timescale 1ns/1ps
module scwg_host_model (
   input wire clk_i,
   output logic frame_valid_o = 1'h0,
   output logic [15:0] frame_o = 16'h0000
);
   task send(input logic [6:0] code, input logic bad, input logic [7:0] data);
      @(negedge clk_i);
      frame_valid_o = 1'h1;
      frame_o = {code, ^code ^ bad, data};
      @(negedge clk_i);
      frame_valid_o = 1'h0;
      // Released lines must not keep the old frame
      frame_o = ~frame_o;
   endtask
endmodule // scwg_host_model

// ===== bench/scwg_properties.sv
// Checker for the serial command write gate
`timescale 1ns/1ps
module scwg_properties (
   input wire sys_clk_i,
   input wire reset_i,
   input wire frame_valid_i,
   input wire [15:0] frame_i,
   input wire diag_state_i,
   input wire [7:0] resp_data_o,
   input wire resp_valid_o,
   input wire write_done_o,
   input wire write_refused_o,
   input wire parity_error_o,
   input wire lock_engaged_o,
   input wire [55:0] regs_flat_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [1:0] hist;
   // Lock output lags, so gate checks need two quiet cycles
   always @(posedge sys_clk_i) hist <= {hist[0], frame_valid_i};
   wire quiet = hist == 2'h0;
   wire gw = frame_valid_i && (frame_i[15:8] inside {8'hDB, 8'hA9, 8'h99, 8'hED, 8'h09, 8'h35, 8'h63});
   resp_pulse_a: assert property (frame_valid_i && !(^frame_i[15:8]) |=> resp_valid_o)
      else $error("no response");
   odd_parity_a: assert property (frame_valid_i && ^frame_i[15:8] |=> parity_error_o && resp_data_o == 8'h00)
      else $error("parity missed");
   diag_gate_a: assert property (gw && !diag_state_i |=> write_refused_o && !write_done_o)
      else $error("write outside diag");
   lock_gate_a: assert property (gw && lock_engaged_o && quiet |=> write_refused_o)
      else $error("write while locked");
   open_write_a: assert property (gw && diag_state_i && !lock_engaged_o && quiet |=> write_done_o)
      else $error("write refused");
   refused_hold_a: assert property (write_refused_o |=> $stable(regs_flat_o))
      else $error("refused write stored");
   lock_set_a: assert property (frame_valid_i && frame_i == 16'hBDAA |-> ##[1:2] lock_engaged_o)
      else $error("lock missed");
   lock_clear_a: assert property (frame_valid_i && frame_i == 16'hBB55 |-> ##[1:2] !lock_engaged_o)
      else $error("unlock missed");
   cover property (write_done_o);
   cover property (write_refused_o && lock_engaged_o);
   cover property (parity_error_o);
endmodule // scwg_properties
bind scwg_write_gate scwg_properties i_props (
   .sys_clk_i(sys_clk_i),
   .reset_i(reset_i),
   .frame_valid_i(frame_valid_i),
   .frame_i(frame_i),
   .diag_state_i(diag_state_i),
   .resp_data_o(resp_data_o),
   .resp_valid_o(resp_valid_o),
   .write_done_o(write_done_o),
   .write_refused_o(write_refused_o),
   .parity_error_o(parity_error_o),
   .lock_engaged_o(lock_engaged_o),
   .regs_flat_o(regs_flat_o)
);

// ===== bench/tb.sv
// Bench for the serial command write gate
`timescale 1ns/1ps
module tb;
   logic sys_clk_i = 1'h0, reset_i = 1'h1, diag_state_i = 1'h0;
   wire frame_valid_i, resp_valid_o, write_done_o, write_refused_o, parity_error_o, lock_engaged_o;
   wire [15:0] frame_i;
   wire [7:0] resp_data_o;
   wire [55:0] regs_flat_o;
   int fails = 0, samples_checked = 0, cyc = 0;
   logic [6:0] wr [7] = '{7'h6D, 7'h54, 7'h4C, 7'h76, 7'h04, 7'h1A, 7'h31};
   logic [6:0] rd [7] = '{7'h18, 7'h55, 7'h1C, 7'h17, 7'h02, 7'h1D, 7'h2D};
   logic [7:0] v;
   always #12.5 sys_clk_i = ~sys_clk_i;
   scwg_host_model i_host (.clk_i(sys_clk_i), .frame_valid_o(frame_valid_i), .frame_o(frame_i));
   scwg_write_gate #(.REV_MAJOR(4'h2), .REV_MINOR(4'h7)) i_dut (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .frame_valid_i(frame_valid_i),
      .frame_i(frame_i),
      .diag_state_i(diag_state_i),
      .resp_data_o(resp_data_o),
      .resp_valid_o(resp_valid_o),
      .write_done_o(write_done_o),
      .write_refused_o(write_refused_o),
      .parity_error_o(parity_error_o),
      .lock_engaged_o(lock_engaged_o),
      .regs_flat_o(regs_flat_o)
   );
   task chk(input logic [10:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask
   task xfer(input logic d, input logic [6:0] c, input logic p, input logic [7:0] x, input logic [10:0] e);
      @(negedge sys_clk_i);
      diag_state_i = d;
      i_host.send(c, p, x);
      // Pulses stand only until the next rising edge
      chk({write_done_o, write_refused_o, parity_error_o, resp_data_o}, e);
      chk({10'h000, resp_valid_o}, 11'h001);
   endtask
   task complete_run;
      $display("fails %0d samples_checked %0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      repeat (3) @(negedge sys_clk_i);
      reset_i = 1'h0;
      repeat (2) @(posedge sys_clk_i);
      xfer(1'h1, 7'h06, 1'h0, 8'hFF, 11'h027);
      xfer(1'h1, 7'h06, 1'h1, 8'h00, 11'h100);
      xfer(1'h1, 7'h5E, 1'h0, 8'h55, 11'h000);
      for (int i = 0; i < 7; i++) begin
         v = 8'h30 + 8'(i);
         xfer(1'h0, wr[i], 1'h0, 8'hA5, 11'h200);
         xfer(1'h1, wr[i], 1'h0, v, 11'h400);
         xfer(1'h1, 7'h5E, 1'h0, 8'hAA, 11'h000);
         xfer(1'h1, wr[i], 1'h0, 8'h5A, 11'h200);
         chk({10'h000, lock_engaged_o}, 11'h001);
         xfer(1'h1, 7'h5D, 1'h0, 8'h55, 11'h000);
         xfer(1'h0, rd[i], 1'h0, 8'h00, {3'h0, v});
         chk({3'h0, regs_flat_o[8*i +: 8]}, {3'h0, v});
         chk({10'h000, lock_engaged_o}, 11'h000);
      end
      xfer(1'h1, 7'h06, 1'h0, 8'h00, 11'h027);
      complete_run();
   end
endmodule // tb

// ===== src/scwg_consts.vh
// Constants for the serial command write gate
`ifndef SCWG_CONSTS_VH
`define SCWG_CONSTS_VH

`define SCWG_FRAME_BITS 16
`define SCWG_CMD_MSB 15
`define SCWG_CMD_LSB 8
`define SCWG_DATA_MSB 7
`define SCWG_DATA_LSB 0
`define SCWG_CODE_MSB 7
`define SCWG_CODE_LSB 1
`define SCWG_REG_BITS 8

// 7-bit command codes, parity excluded
`define SCWG_CODE_LOCK 7'h5E
`define SCWG_CODE_UNLOCK 7'h5D
`define SCWG_CODE_RD_REV 7'h06
`define SCWG_CODE_WR_ERR_CFG 7'h6D
`define SCWG_CODE_RD_ERR_CFG 7'h18
`define SCWG_CODE_WR_ERR_STAT 7'h54
`define SCWG_CODE_RD_ERR_STAT 7'h55
`define SCWG_CODE_WR_PWD_THR 7'h4C
`define SCWG_CODE_RD_PWD_THR 7'h1C
`define SCWG_CODE_WR_WIN1 7'h76
`define SCWG_CODE_RD_WIN1 7'h17
`define SCWG_CODE_WR_WIN2 7'h04
`define SCWG_CODE_RD_WIN2 7'h02
`define SCWG_CODE_WR_FUNC_CFG 7'h1A
`define SCWG_CODE_RD_FUNC_CFG 7'h1D
`define SCWG_CODE_WR_CFG_CRC 7'h31
`define SCWG_CODE_RD_CFG_CRC 7'h2D

`define SCWG_LOCK_KEY 8'hAA
`define SCWG_UNLOCK_KEY 8'h55

// Gated register slots
`define SCWG_IDX_ERR_CFG 3'h0
`define SCWG_IDX_ERR_STAT 3'h1
`define SCWG_IDX_PWD_THR 3'h2
`define SCWG_IDX_WIN1 3'h3
`define SCWG_IDX_WIN2 3'h4
`define SCWG_IDX_FUNC_CFG 3'h5
`define SCWG_IDX_CFG_CRC 3'h6
`define SCWG_NUM_REGS 7

`define SCWG_REG_RESET 8'h00
`define SCWG_ZERO_BYTE 8'h00

// Revision field positions
`define SCWG_REV_MINOR_MSB 3
`define SCWG_REV_MINOR_LSB 0
`define SCWG_REV_MAJOR_MSB 7
`define SCWG_REV_MAJOR_LSB 4

`endif

// ===== src/scwg_parity_check.v
// Even-parity check of one command byte
`timescale 1ns/1ps
module scwg_parity_check (
   input wire [7:0] byte_i,
   output wire even_o
);
   assign even_o = ~(^byte_i);
endmodule // scwg_parity_check

// ===== src/scwg_write_gate.v
// Command decoder and write gate for the serial control frame
`timescale 1ns/1ps
`include "scwg_consts.vh"
module scwg_write_gate #(
   parameter [3:0] REV_MAJOR = 4'h1, // Arbitrary value
   parameter [3:0] REV_MINOR = 4'h0  // Arbitrary value
) (
   input wire sys_clk_i,
   input wire reset_i,
   input wire frame_valid_i,
   input wire [15:0] frame_i,
   input wire diag_state_i,
   output reg [7:0] resp_data_o,
   output reg resp_valid_o,
   output reg write_done_o,
   output reg write_refused_o,
   output reg parity_error_o,
   output reg lock_engaged_o,
   output reg [55:0] regs_flat_o
);
   // Frame strobe and state come from the same clock domain.
   wire [7:0] cmd_byte;
   wire [7:0] data_byte;
   wire [6:0] code;
   wire parity_ok;
   wire frame_ok;
   wire bad_frame;
   wire lock_cmd;
   wire unlock_cmd;
   wire write_cmd;
   wire state_refuses;
   wire lock_refuses;
   wire write_granted;
   wire write_blocked;
   reg [7:0] regs_reg [0:`SCWG_NUM_REGS-1];
   reg [7:0] revision_reg;
   reg lock_reg;
   reg [2:0] idx;
   reg is_write;
   reg is_read;
   reg [7:0] rd_next;
   integer i;
   integer j;

   // Slots whose writes land only in the diagnostic state
   function diag_only;
      input [2:0] slot;
      begin
         diag_only = 1'b0;
         if (slot == `SCWG_IDX_ERR_CFG) begin
            diag_only = 1'b1;
         end else if (slot == `SCWG_IDX_ERR_STAT) begin
            diag_only = 1'b1;
         end else if (slot == `SCWG_IDX_PWD_THR) begin
            diag_only = 1'b1;
         end else if (slot == `SCWG_IDX_WIN1) begin
            diag_only = 1'b1;
         end else if (slot == `SCWG_IDX_WIN2) begin
            diag_only = 1'b1;
         end else if (slot == `SCWG_IDX_FUNC_CFG) begin
            diag_only = 1'b1;
         end else if (slot == `SCWG_IDX_CFG_CRC) begin
            diag_only = 1'b1;
         end
      end
   endfunction

   // Slots that the software lock protects; kept apart from the
   // state table so one can be relaxed without the other
   function lock_protected;
      input [2:0] slot;
      begin
         lock_protected = 1'b0;
         if (slot == `SCWG_IDX_ERR_CFG) begin
            lock_protected = 1'b1;
         end else if (slot == `SCWG_IDX_ERR_STAT) begin
            lock_protected = 1'b1;
         end else if (slot == `SCWG_IDX_PWD_THR) begin
            lock_protected = 1'b1;
         end else if (slot == `SCWG_IDX_WIN1) begin
            lock_protected = 1'b1;
         end else if (slot == `SCWG_IDX_WIN2) begin
            lock_protected = 1'b1;
         end else if (slot == `SCWG_IDX_FUNC_CFG) begin
            lock_protected = 1'b1;
         end else if (slot == `SCWG_IDX_CFG_CRC) begin
            lock_protected = 1'b1;
         end
      end
   endfunction

   assign cmd_byte = frame_i[`SCWG_CMD_MSB:`SCWG_CMD_LSB];
   assign data_byte = frame_i[`SCWG_DATA_MSB:`SCWG_DATA_LSB];
   assign code = cmd_byte[`SCWG_CODE_MSB:`SCWG_CODE_LSB];

   // Odd parity voids the whole frame, lock commands included
   assign frame_ok = frame_valid_i && parity_ok;
   assign bad_frame = frame_valid_i && !parity_ok;
   assign lock_cmd = frame_ok && (code == `SCWG_CODE_LOCK) && (data_byte == `SCWG_LOCK_KEY);
   assign unlock_cmd = frame_ok && (code == `SCWG_CODE_UNLOCK) && (data_byte == `SCWG_UNLOCK_KEY);
   assign write_cmd = frame_ok && is_write;
   // State and lock are taken at the frame's own edge
   assign state_refuses = diag_only(idx) && !diag_state_i;
   assign lock_refuses = lock_protected(idx) && lock_reg;
   assign write_granted = write_cmd && !state_refuses && !lock_refuses;
   assign write_blocked = write_cmd && (state_refuses || lock_refuses);

   scwg_parity_check u_parity (
      .byte_i(cmd_byte),
      .even_o(parity_ok)
   );

   // Map code to gated slot
   always @* begin
      idx = `SCWG_IDX_ERR_CFG;
      is_write = 1'b0;
      is_read = 1'b0;
      case (code)
         `SCWG_CODE_WR_ERR_CFG: begin
            idx = `SCWG_IDX_ERR_CFG;
            is_write = 1'b1;
         end
         `SCWG_CODE_WR_ERR_STAT: begin
            idx = `SCWG_IDX_ERR_STAT;
            is_write = 1'b1;
         end
         `SCWG_CODE_WR_PWD_THR: begin
            idx = `SCWG_IDX_PWD_THR;
            is_write = 1'b1;
         end
         `SCWG_CODE_WR_WIN1: begin
            idx = `SCWG_IDX_WIN1;
            is_write = 1'b1;
         end
         `SCWG_CODE_WR_WIN2: begin
            idx = `SCWG_IDX_WIN2;
            is_write = 1'b1;
         end
         `SCWG_CODE_WR_FUNC_CFG: begin
            idx = `SCWG_IDX_FUNC_CFG;
            is_write = 1'b1;
         end
         `SCWG_CODE_WR_CFG_CRC: begin
            idx = `SCWG_IDX_CFG_CRC;
            is_write = 1'b1;
         end
         `SCWG_CODE_RD_ERR_CFG: begin
            idx = `SCWG_IDX_ERR_CFG;
            is_read = 1'b1;
         end
         `SCWG_CODE_RD_ERR_STAT: begin
            idx = `SCWG_IDX_ERR_STAT;
            is_read = 1'b1;
         end
         `SCWG_CODE_RD_PWD_THR: begin
            idx = `SCWG_IDX_PWD_THR;
            is_read = 1'b1;
         end
         `SCWG_CODE_RD_WIN1: begin
            idx = `SCWG_IDX_WIN1;
            is_read = 1'b1;
         end
         `SCWG_CODE_RD_WIN2: begin
            idx = `SCWG_IDX_WIN2;
            is_read = 1'b1;
         end
         `SCWG_CODE_RD_FUNC_CFG: begin
            idx = `SCWG_IDX_FUNC_CFG;
            is_read = 1'b1;
         end
         `SCWG_CODE_RD_CFG_CRC: begin
            idx = `SCWG_IDX_CFG_CRC;
            is_read = 1'b1;
         end
         default: begin
            idx = `SCWG_IDX_ERR_CFG;
         end
      endcase
   end

   // Response byte, zero for writes and unknown codes
   always @* begin
      rd_next = `SCWG_ZERO_BYTE;
      if (code == `SCWG_CODE_RD_REV) begin
         rd_next = revision_reg;
      end else if (is_read) begin
         rd_next = regs_reg[idx];
      end
   end

   // Revision fixed by reset; no command writes it
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         revision_reg[`SCWG_REV_MAJOR_MSB:`SCWG_REV_MAJOR_LSB] <= REV_MAJOR;
         revision_reg[`SCWG_REV_MINOR_MSB:`SCWG_REV_MINOR_LSB] <= REV_MINOR;
      end else begin
         revision_reg <= revision_reg;
      end
   end

   // Lock and unlock are honoured in any device state
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         lock_reg <= 1'b0;
      end else if (lock_cmd) begin
         lock_reg <= 1'b1;
      end else if (unlock_cmd) begin
         lock_reg <= 1'b0;
      end
   end

   // A refused write falls through, so the slot keeps its value
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         for (i = 0; i < `SCWG_NUM_REGS; i = i + 1) begin
            regs_reg[i] <= `SCWG_REG_RESET;
         end
      end else if (write_granted) begin
         regs_reg[idx] <= data_byte;
      end
   end

   // Response byte holds until the next frame
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         resp_data_o <= `SCWG_ZERO_BYTE;
      end else if (bad_frame) begin
         resp_data_o <= `SCWG_ZERO_BYTE;
      end else if (frame_ok) begin
         resp_data_o <= rd_next;
      end
   end

   // One-cycle pulses; every frame gets a response strobe
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         resp_valid_o <= 1'b0;
      end else begin
         resp_valid_o <= frame_valid_i;
      end
   end

   // Done and refused never rise together for one frame
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         write_done_o <= 1'b0;
      end else begin
         write_done_o <= write_granted;
      end
   end

   // A refusal does not say which gate tripped
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         write_refused_o <= 1'b0;
      end else begin
         write_refused_o <= write_blocked;
      end
   end

   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         parity_error_o <= 1'b0;
      end else begin
         parity_error_o <= bad_frame;
      end
   end

   // Mirrors trail the internal state by one cycle
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         lock_engaged_o <= 1'b0;
      end else begin
         lock_engaged_o <= lock_reg;
      end
   end

   // Flat copy shows every slot without a read frame
   always @(posedge sys_clk_i) begin
      if (reset_i) begin
         regs_flat_o <= {`SCWG_NUM_REGS{`SCWG_REG_RESET}};
      end else begin
         for (j = 0; j < `SCWG_NUM_REGS; j = j + 1) begin
            regs_flat_o[j*`SCWG_REG_BITS +: `SCWG_REG_BITS] <= regs_reg[j];
         end
      end
   end
endmodule // scwg_write_gate
